// [spfs_top.v]
/*
 shared pin function select: gpio muxing under software control, plus strap-fixed
 ownership of serial/cell pins and host/pci pins.
 assumes axi4-lite master per protocol, straps synchronous to aclk.
*/
// Register access over AXI4-Lite and the register addresses were left to the implementer.
// Overview of operation
// [R1] software-controlled pins follow their control bits at any time, reset aside
// [R2] strap pins are selected only at reset; one owner afterwards
// [R3] after reset clock outputs keep clock function, their gpio enables clear
// [R4] gpio enable at one hands the pin to gpio
// [R5] gpio direction zero means input, one means driven output
// [R6] gpio lines nine to fifteen usable only when pci strap is zero
// [R7] default: shared pins are serial port one, cell interface off
// [R8] cell strap one routes shared pins, address lines too, to cell interface
// [R9] default: shared host pins are host port, pci off
// [R10] pci strap one routes host data and control pins to pci
// [R11] disabled cell interface or pci holds its own pins high impedance
// [R12] outside controller drives non-strap address pins to reset level or not at all
// [R13] cell strap zero: serial pins live, cell pins hi-z; one reverses it
// [R14] serial port two off only when pci on and its select is zero; code also turns it off with pci on when sp2_sw_sel_reg is zero
// [R15] strap ownership captured at reset release, held until next reset
`timescale 1ns/1ns
`include "spfs_regs.vh"
module spfs_top #(
	parameter NGP   = 16,
	parameter NCELL = 8,
	parameter NSP1  = 7,
	parameter NHOST = 40,
	parameter NCO   = 8,
	parameter NPCI  = 8
) (
	input  wire             aclk,
	input  wire             aresetn,
	input  wire [11:0]      s_axi_awaddr,
	input  wire             s_axi_awvalid,
	output reg              s_axi_awready,
	input  wire [31:0]      s_axi_wdata,
	input  wire [3:0]       s_axi_wstrb,
	input  wire             s_axi_wvalid,
	output reg              s_axi_wready,
	output reg  [1:0]       s_axi_bresp,
	output reg              s_axi_bvalid,
	input  wire             s_axi_bready,
	input  wire [11:0]      s_axi_araddr,
	input  wire             s_axi_arvalid,
	output reg              s_axi_arready,
	output reg  [31:0]      s_axi_rdata,
	output reg  [1:0]       s_axi_rresp,
	output reg              s_axi_rvalid,
	input  wire             s_axi_rready,
	input  wire             cell_if_select_strap,
	input  wire             pci_select_strap,
	input  wire             serial_port2_select,
	input  wire [NGP-1:0]   gp_pin_i,
	output wire [NGP-1:0]   gp_pin_o,
	output wire [NGP-1:0]   gp_pin_oe,
	input  wire [NGP-1:0]   periph_gp_o,
	input  wire [NGP-1:0]   periph_gp_oe,
	output wire [NGP-1:0]   periph_gp_i,
	input  wire [NSP1-1:0]  mux1_pin_i,
	output reg  [NSP1-1:0]  mux1_pin_o,
	output reg  [NSP1-1:0]  mux1_pin_oe,
	input  wire [NSP1-1:0]  sp1_o,
	input  wire [NSP1-1:0]  sp1_oe,
	output reg  [NSP1-1:0]  sp1_i,
	input  wire [NSP1-1:0]  cell_mux_o,
	input  wire [NSP1-1:0]  cell_mux_oe,
	output reg  [NSP1-1:0]  cell_mux_i,
	input  wire [NCELL-1:0] cell_solo_o,
	input  wire [NCELL-1:0] cell_solo_oe,
	output reg  [NCELL-1:0] cell_solo_pin_o,
	output reg  [NCELL-1:0] cell_solo_pin_oe,
	input  wire [NCO-1:0]   sp1_solo_o,
	input  wire [NCO-1:0]   sp1_solo_oe,
	output reg  [NCO-1:0]   sp1_solo_pin_o,
	output reg  [NCO-1:0]   sp1_solo_pin_oe,
	input  wire [NHOST-1:0] mux2_pin_i,
	output reg  [NHOST-1:0] mux2_pin_o,
	output reg  [NHOST-1:0] mux2_pin_oe,
	input  wire [NHOST-1:0] host_o,
	input  wire [NHOST-1:0] host_oe,
	output reg  [NHOST-1:0] host_i,
	input  wire [NHOST-1:0] pci_o,
	input  wire [NHOST-1:0] pci_oe,
	output reg  [NHOST-1:0] pci_i,
	input  wire [NPCI-1:0]  pci_solo_o,
	input  wire [NPCI-1:0]  pci_solo_oe,
	output reg  [NPCI-1:0]  pci_solo_pin_o,
	output reg  [NPCI-1:0]  pci_solo_pin_oe,
	output reg              cell_if_enabled,
	output reg              pci_enabled,
	output reg              serial_port_two_enabled
);
	// ----------------------------------------
	// strap capture and software state
	// ----------------------------------------
	wire            cell_on;
	wire            pci_on;
	wire [NGP-1:0]  gp_allowed;
	wire [NGP-1:0]  gpio_in_w;
	reg  [NGP-1:0]  gpio_pin_enable_reg;
	reg  [NGP-1:0]  gpio_pin_direction_reg;
	reg  [NGP-1:0]  gpio_out_reg;
	reg             sp2_sw_sel_reg;

	spfs_strap_latch u_strap (
		.aclk                 (aclk),
		.aresetn              (aresetn),
		.cell_if_select_strap (cell_if_select_strap),
		.pci_select_strap     (pci_select_strap),
		.cell_if_on           (cell_on),
		.pci_on               (pci_on)
	); // R2 R15

	// ----------------------------------------
	// gpio cells
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < NGP; g = g + 1) begin : gp
			if (g >= `SPFS_GP_PCI_LO && g <= `SPFS_GP_PCI_HI) begin : pcig
				assign gp_allowed[g] = ~pci_on; // R6
			end else begin : freeg
				assign gp_allowed[g] = 1'b1; // R1
			end
			spfs_gpio_cell u_cell (
				.aclk               (aclk),
				.aresetn            (aresetn),
				.allowed            (gp_allowed[g]),
				.gpio_pin_enable    (gpio_pin_enable_reg[g]),
				.gpio_pin_direction (gpio_pin_direction_reg[g]),
				.gpio_out           (gpio_out_reg[g]),
				.periph_o           (periph_gp_o[g]),
				.periph_oe          (periph_gp_oe[g]),
				.pin_i              (gp_pin_i[g]),
				.pin_o              (gp_pin_o[g]),
				.pin_oe             (gp_pin_oe[g]),
				.gpio_in            (gpio_in_w[g]),
				.periph_i           (periph_gp_i[g])
			); // R4 R5 R3
		end
	endgenerate

	// ----------------------------------------
	// strap-owned pins
	// ----------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			mux1_pin_o              <= {NSP1{1'b0}};
			mux1_pin_oe             <= {NSP1{1'b0}};
			sp1_i                   <= {NSP1{1'b0}};
			cell_mux_i              <= {NSP1{1'b0}};
			cell_solo_pin_o         <= {NCELL{1'b0}};
			cell_solo_pin_oe        <= {NCELL{1'b0}};
			sp1_solo_pin_o          <= {NCO{1'b0}};
			sp1_solo_pin_oe         <= {NCO{1'b0}};
			mux2_pin_o              <= {NHOST{1'b0}};
			mux2_pin_oe             <= {NHOST{1'b0}};
			host_i                  <= {NHOST{1'b0}};
			pci_i                   <= {NHOST{1'b0}};
			pci_solo_pin_o          <= {NPCI{1'b0}};
			pci_solo_pin_oe         <= {NPCI{1'b0}};
			cell_if_enabled         <= 1'b0;
			pci_enabled             <= 1'b0;
			serial_port_two_enabled <= 1'b1;
		end else begin
			cell_if_enabled <= cell_on; // R7 R8
			pci_enabled     <= pci_on;  // R9 R10
			// live select; only pci on with serial_port2_select or sp2_sw_sel_reg low shuts it off
			serial_port_two_enabled <= ~(pci_on & ~(serial_port2_select & sp2_sw_sel_reg)); // R14
			if (cell_on) begin
				mux1_pin_o  <= cell_mux_o;  // R8
				mux1_pin_oe <= cell_mux_oe;
			end else begin
				mux1_pin_o  <= sp1_o;       // R7
				mux1_pin_oe <= sp1_oe;
			end
			sp1_i      <= cell_on ? {NSP1{1'b0}} : mux1_pin_i;
			cell_mux_i <= cell_on ? mux1_pin_i : {NSP1{1'b0}};
			// losing side's standalone pins released to hi-z
			cell_solo_pin_o  <= cell_on ? cell_solo_o : {NCELL{1'b0}};   // R11 R13
			cell_solo_pin_oe <= cell_on ? cell_solo_oe : {NCELL{1'b0}};  // R11 R13
			sp1_solo_pin_o   <= cell_on ? {NCO{1'b0}} : sp1_solo_o;      // R13
			sp1_solo_pin_oe  <= cell_on ? {NCO{1'b0}} : sp1_solo_oe;     // R13
			if (pci_on) begin
				mux2_pin_o  <= pci_o;   // R10
				mux2_pin_oe <= pci_oe;
			end else begin
				mux2_pin_o  <= host_o;  // R9
				mux2_pin_oe <= host_oe;
			end
			host_i          <= pci_on ? {NHOST{1'b0}} : mux2_pin_i;
			pci_i           <= pci_on ? mux2_pin_i : {NHOST{1'b0}};
			pci_solo_pin_o  <= pci_on ? pci_solo_o : {NPCI{1'b0}};   // R11
			pci_solo_pin_oe <= pci_on ? pci_solo_oe : {NPCI{1'b0}};  // R11
		end
	end

	// ----------------------------------------
	// axi4-lite write
	// ----------------------------------------
	reg [11:0] aw_addr_reg;
	reg        aw_have_reg;
	reg [31:0] w_data_reg;
	reg [3:0]  w_strb_reg;
	reg        w_have_reg;
	wire [31:0] wmask;

	assign wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
			{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_reg            <= 1'b0;
			w_have_reg             <= 1'b0;
			aw_addr_reg            <= 12'h000;
			w_data_reg             <= 32'h00000000;
			w_strb_reg             <= 4'h0;
			s_axi_awready          <= 1'b0;
			s_axi_wready           <= 1'b0;
			s_axi_bvalid           <= 1'b0;
			s_axi_bresp            <= `SPFS_RESP_OKAY;
			gpio_pin_enable_reg    <= `SPFS_GPIO_EN_RST;  // R3
			gpio_pin_direction_reg <= `SPFS_GPIO_DIR_RST;
			gpio_out_reg           <= `SPFS_GPIO_OUT_RST;
			sp2_sw_sel_reg         <= `SPFS_SP2_SEL_RST;
		end else begin
			s_axi_awready <= ~aw_have_reg & ~s_axi_awready & ~s_axi_bvalid & s_axi_awvalid;
			s_axi_wready  <= ~w_have_reg & ~s_axi_wready & ~s_axi_bvalid & s_axi_wvalid;
			if (s_axi_awvalid & s_axi_awready) begin
				aw_have_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_have_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (aw_have_reg & w_have_reg & ~s_axi_bvalid) begin
				aw_have_reg  <= 1'b0;
				w_have_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= `SPFS_RESP_OKAY;
				case (aw_addr_reg)
				`SPFS_GPIO_EN_OFS: gpio_pin_enable_reg <= (gpio_pin_enable_reg
						& ~wmask[15:0]) | (w_data_reg[15:0] & wmask[15:0]); // R1 R4
				`SPFS_GPIO_DIR_OFS: gpio_pin_direction_reg <= (gpio_pin_direction_reg
						& ~wmask[15:0]) | (w_data_reg[15:0] & wmask[15:0]); // R5
				`SPFS_GPIO_OUT_OFS: gpio_out_reg <= (gpio_out_reg & ~wmask[15:0])
						| (w_data_reg[15:0] & wmask[15:0]);
				`SPFS_SP2_SEL_OFS: if (w_strb_reg[0]) begin
						sp2_sw_sel_reg <= w_data_reg[0];
					end
				`SPFS_GPIO_IN_OFS, `SPFS_STATUS_OFS: s_axi_bresp <= `SPFS_RESP_OKAY;
				default: s_axi_bresp <= `SPFS_RESP_SLVERR;
				endcase
			end else if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// axi4-lite read
	// ----------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `SPFS_RESP_OKAY;
		end else begin
			s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
			if (s_axi_arvalid & s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= `SPFS_RESP_OKAY;
				case (s_axi_araddr)
				`SPFS_GPIO_EN_OFS:  s_axi_rdata <= {16'h0000, gpio_pin_enable_reg};
				`SPFS_GPIO_DIR_OFS: s_axi_rdata <= {16'h0000, gpio_pin_direction_reg};
				`SPFS_GPIO_OUT_OFS: s_axi_rdata <= {16'h0000, gpio_out_reg};
				`SPFS_GPIO_IN_OFS:  s_axi_rdata <= {16'h0000, gpio_in_w};
				`SPFS_STATUS_OFS:   s_axi_rdata <= {29'h00000000, serial_port_two_enabled,
						pci_enabled, cell_if_enabled};
				`SPFS_SP2_SEL_OFS:  s_axi_rdata <= {31'h00000000, sp2_sw_sel_reg};
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= `SPFS_RESP_SLVERR;
				end
				endcase
			end else if (s_axi_rvalid & s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule

// [spfs_regs.vh]
/*
 pin function select constants: register offsets, field positions, reset values.
 assumes a 32-bit axi4-lite register bus with word-aligned offsets.
*/
`ifndef SPFS_REGS_VH
`define SPFS_REGS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define SPFS_GPIO_EN_OFS     12'h000
`define SPFS_GPIO_DIR_OFS    12'h004
`define SPFS_GPIO_OUT_OFS    12'h008
`define SPFS_GPIO_IN_OFS     12'h00C
`define SPFS_STATUS_OFS      12'h010
`define SPFS_SP2_SEL_OFS     12'h014

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define SPFS_GPIO_BITS       16
`define SPFS_GP_CLK4_BIT     1
`define SPFS_GP_CLK6_BIT     2
`define SPFS_GP_SCLK2_BIT    8
`define SPFS_GP_PCI_LO       9
`define SPFS_GP_PCI_HI       15
`define SPFS_ST_CELL_BIT     0
`define SPFS_ST_PCI_BIT      1
`define SPFS_ST_SP2_BIT      2
`define SPFS_GPIO_EN_RST     16'h0000
`define SPFS_GPIO_DIR_RST    16'h0000
`define SPFS_GPIO_OUT_RST    16'h0000
`define SPFS_SP2_SEL_RST     1'b1
`define SPFS_RESP_OKAY       2'h0
`define SPFS_RESP_SLVERR     2'h2

`endif

// [spfs_strap_latch.v]
/*
 strap latch: captures strap levels on the cycle reset is released, then holds.
 assumes straps are synchronous to aclk and stable around reset release.
*/
`timescale 1ns/1ns
module spfs_strap_latch (
	input  wire aclk,
	input  wire aresetn,
	input  wire cell_if_select_strap,
	input  wire pci_select_strap,
	output reg  cell_if_on,
	output reg  pci_on
);
	reg in_reset_reg;

	// straps sampled at release, never loaded from a port under reset
	always @(posedge aclk) begin
		if (!aresetn) begin
			in_reset_reg <= 1'b1;
			cell_if_on   <= 1'b0;
			pci_on       <= 1'b0;
		end else begin
			in_reset_reg <= 1'b0;
			if (in_reset_reg) begin
				cell_if_on <= cell_if_select_strap; // R2 R15
				pci_on     <= pci_select_strap;
			end
		end
	end
endmodule

// [spfs_gpio_cell.v]
/*
 one gpio cell: picks pin drive between gpio output and a default peripheral.
 assumes the peripheral drive and enable arrive already registered.
*/
`timescale 1ns/1ns
module spfs_gpio_cell (
	input  wire aclk,
	input  wire aresetn,
	input  wire allowed,
	input  wire gpio_pin_enable,
	input  wire gpio_pin_direction,
	input  wire gpio_out,
	input  wire periph_o,
	input  wire periph_oe,
	input  wire pin_i,
	output reg  pin_o,
	output reg  pin_oe,
	output reg  gpio_in,
	output reg  periph_i
);
	wire gpio_mode;

	assign gpio_mode = allowed & gpio_pin_enable;

	always @(posedge aclk) begin
		if (!aresetn) begin
			pin_o    <= 1'b0;
			pin_oe   <= 1'b0;
			gpio_in  <= 1'b0;
			periph_i <= 1'b0;
		end else begin
			if (gpio_mode) begin
				pin_o  <= gpio_out;
				pin_oe <= gpio_pin_direction;
			end else begin
				pin_o  <= periph_o;
				pin_oe <= periph_oe;
			end
			gpio_in  <= gpio_mode ? pin_i : 1'b0;
			periph_i <= gpio_mode ? 1'b0 : pin_i;
		end
	end
endmodule

// [spfs_top_monitor.sv]
/*
 checker for spfs_top: pin ownership, strap hold, serial port two enable.
 assumes binding onto spfs_top; pin outputs lag their causes by one cycle.
*/
`timescale 1ns/1ns
module spfs_top_monitor #(
	parameter NSP1  = 7,
	parameter NHOST = 40,
	parameter NCELL = 8,
	parameter NCO   = 8,
	parameter NPCI  = 8
) (
	input wire             aclk,
	input wire             aresetn,
	input wire [NSP1-1:0]  mux1_pin_o,
	input wire [NSP1-1:0]  sp1_o,
	input wire [NSP1-1:0]  cell_mux_o,
	input wire [NSP1-1:0]  mux1_pin_i,
	input wire [NSP1-1:0]  sp1_i,
	input wire [NSP1-1:0]  cell_mux_i,
	input wire [NCELL-1:0] cell_solo_o,
	input wire [NCELL-1:0] cell_solo_oe,
	input wire [NCELL-1:0] cell_solo_pin_o,
	input wire [NCO-1:0]   sp1_solo_o,
	input wire [NCO-1:0]   sp1_solo_oe,
	input wire [NCO-1:0]   sp1_solo_pin_o,
	input wire [NPCI-1:0]  pci_solo_o,
	input wire [NPCI-1:0]  pci_solo_oe,
	input wire [NPCI-1:0]  pci_solo_pin_o,
	input wire [NHOST-1:0] mux2_pin_i,
	input wire [NHOST-1:0] host_i,
	input wire [NHOST-1:0] pci_i,
	input wire [NCELL-1:0] cell_solo_pin_oe,
	input wire [NCO-1:0]   sp1_solo_pin_oe,
	input wire [NPCI-1:0]  pci_solo_pin_oe,
	input wire [NHOST-1:0] mux2_pin_o,
	input wire [NHOST-1:0] host_o,
	input wire [NHOST-1:0] pci_o,
	input wire             serial_port2_select,
	input wire             cell_if_enabled,
	input wire             pci_enabled,
	input wire             serial_port_two_enabled
);
// ---
// settle counter: straps reach the outputs a few edges after release
// ---
reg  [2:0] up_cnt_reg;
wire       settled = (up_cnt_reg == 3'h7);
always @(posedge aclk) begin
	if (!aresetn)
		up_cnt_reg <= 3'h0;
	else if (!settled)
		up_cnt_reg <= up_cnt_reg + 3'h1;
end
default clocking @(posedge aclk); endclocking
default disable iff (!aresetn);
sequence sp2_drop;
	(settled && pci_enabled && !serial_port2_select) [*2];
endsequence
a_cell_mux_own: assert property (settled && cell_if_enabled |->
	mux1_pin_o == $past(cell_mux_o))
	else $error("shared serial pins not driven by cell interface");
a_sp1_in_route: assert property (settled && !cell_if_enabled |->
	sp1_i == $past(mux1_pin_i) && cell_mux_i == '0)
	else $error("serial one input not routed from shared pins");
a_cell_in_route: assert property (settled && cell_if_enabled |->
	cell_mux_i == $past(mux1_pin_i) && sp1_i == '0)
	else $error("cell input not routed from shared pins");
a_host_in_route: assert property (settled && !pci_enabled |->
	host_i == $past(mux2_pin_i) && pci_i == '0)
	else $error("host input not routed from shared pins");
a_pci_in_route: assert property (settled && pci_enabled |->
	pci_i == $past(mux2_pin_i) && host_i == '0)
	else $error("pci input not routed from shared pins");
a_cell_solo_drv: assert property (settled && cell_if_enabled |->
	cell_solo_pin_o == $past(cell_solo_o) && cell_solo_pin_oe == $past(cell_solo_oe))
	else $error("standalone cell pins not driven by cell interface");
a_sp1_solo_drv: assert property (settled && !cell_if_enabled |->
	sp1_solo_pin_o == $past(sp1_solo_o) && sp1_solo_pin_oe == $past(sp1_solo_oe))
	else $error("standalone serial pins not driven by serial port one");
a_pci_solo_drv: assert property (settled && pci_enabled |->
	pci_solo_pin_o == $past(pci_solo_o) && pci_solo_pin_oe == $past(pci_solo_oe))
	else $error("standalone pci pins not driven by pci");
a_sp1_mux_own: assert property (settled && !cell_if_enabled |-> mux1_pin_o == $past(sp1_o))
	else $error("shared serial pins not driven by serial port one");
a_cell_solo_hiz: assert property (settled && !cell_if_enabled |-> cell_solo_pin_oe == '0)
	else $error("standalone cell pins driven while cell off");
a_sp1_solo_hiz: assert property (settled && cell_if_enabled |-> sp1_solo_pin_oe == '0)
	else $error("standalone serial pins driven while cell on");
a_pci_solo_hiz: assert property (settled && !pci_enabled |-> pci_solo_pin_oe == '0)
	else $error("standalone pci pins driven while pci off");
a_host_mux_own: assert property (settled && !pci_enabled |-> mux2_pin_o == $past(host_o))
	else $error("host pins not driven by host port");
a_pci_mux_own: assert property (settled && pci_enabled |-> mux2_pin_o == $past(pci_o))
	else $error("host pins not driven by pci");
a_strap_hold: assert property (settled |-> $stable(cell_if_enabled) && $stable(pci_enabled))
	else $error("strap ownership changed after reset");
a_sp2_live: assert property (settled && !pci_enabled |-> serial_port_two_enabled)
	else $error("serial port two off with pci off");
a_sp2_off: assert property (sp2_drop |-> !serial_port_two_enabled)
	else $error("serial port two still on");
endmodule
bind spfs_top spfs_top_monitor #(.NSP1(NSP1), .NHOST(NHOST), .NCELL(NCELL), .NCO(NCO),
	.NPCI(NPCI)) u_spfs_top_monitor (.*);

// [spfs_board.sv]
/*
 board model: strap resistors and outside devices on the shared pads.
 assumes pads driven by the design win; otherwise the outside value shows.
*/
`timescale 1ns/1ns
module spfs_board (
	input  wire logic        aclk,
	input  wire logic        cell_pull,
	input  wire logic        pci_pull,
	input  wire logic [15:0] ext_gp,
	input  wire logic [15:0] gp_pin_o,
	input  wire logic [15:0] gp_pin_oe,
	output wire logic [15:0] gp_pin_i,
	input  wire logic [6:0]  mux1_pin_o,
	input  wire logic [6:0]  mux1_pin_oe,
	output wire logic [6:0]  mux1_pin_i,
	input  wire logic [39:0] mux2_pin_o,
	input  wire logic [39:0] mux2_pin_oe,
	output wire logic [39:0] mux2_pin_i,
	output wire logic        cell_if_select_strap,
	output wire logic        pci_select_strap
);
logic flip = 1'b0;
always @(posedge aclk) flip <= ~flip;
// straps held at a firm level through reset, never fought
assign cell_if_select_strap = cell_pull;
assign pci_select_strap = pci_pull;
// undriven serial and host pads wander so a stale value never passes; gpio pads show ext_gp
assign gp_pin_i = gp_pin_oe & gp_pin_o | ~gp_pin_oe & ext_gp;
assign mux1_pin_i = mux1_pin_oe & mux1_pin_o | ~mux1_pin_oe & {7{flip}};
assign mux2_pin_i = mux2_pin_oe & mux2_pin_o | ~mux2_pin_oe & {40{flip}};
endmodule

// [spfs_top_tb_top.sv]
/*
 testbench for spfs_top: axi4-lite master, strap resets, pin ownership checks.
 assumes spfs_board models the pads and straps.
*/
`timescale 1ns/1ns
`include "spfs_regs.vh"
module spfs_top_tb_top;
logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
logic        arvalid = 0, rready = 0, sp2_sel = 1, cell_pull = 0, pci_pull = 0;
logic [11:0] awaddr = 0, araddr = 0;
logic [31:0] wdata = 0, seed = 32'h9DEC;
logic [287:0] pv = '0;
logic [15:0] ext = 16'h0000;
wire         awready, wready, bvalid, arready, rvalid, cstrap, pstrap, cen, pen, sen;
wire [1:0]   bresp, rresp;
wire [31:0]  rdata;
wire [15:0]  gp_i, gp_o, gp_oe, pg_i;
wire [6:0]   m1_i, m1_o, m1_oe;
wire [7:0]   cs_oe, ss_oe, ps_oe;
wire [39:0]  m2_i, m2_o, m2_oe;
int          mismatches = 0, tests_run = 0;
logic [33:0] rq[$];
logic [1:0]  bq[$];
always #5 aclk = ~aclk;
spfs_top u_spfs_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
	.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
	.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
	.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
	.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
	.s_axi_rready(rready), .cell_if_select_strap(cstrap), .pci_select_strap(pstrap),
	.serial_port2_select(sp2_sel), .gp_pin_i(gp_i), .gp_pin_o(gp_o), .gp_pin_oe(gp_oe),
	.periph_gp_o(pv[15:0]), .periph_gp_oe(pv[31:16]), .periph_gp_i(pg_i), .mux1_pin_i(m1_i),
	.mux1_pin_o(m1_o), .mux1_pin_oe(m1_oe), .sp1_o(pv[38:32]), .sp1_oe(pv[45:39]), .sp1_i(),
	.cell_mux_o(pv[52:46]), .cell_mux_oe(pv[59:53]), .cell_mux_i(), .cell_solo_o(pv[67:60]),
	.cell_solo_oe(pv[75:68]), .cell_solo_pin_o(), .cell_solo_pin_oe(cs_oe),
	.sp1_solo_o(pv[83:76]), .sp1_solo_oe(pv[91:84]), .sp1_solo_pin_o(), .sp1_solo_pin_oe(ss_oe),
	.mux2_pin_i(m2_i), .mux2_pin_o(m2_o), .mux2_pin_oe(m2_oe), .host_o(pv[131:92]),
	.host_oe(pv[171:132]), .host_i(), .pci_o(pv[211:172]), .pci_oe(pv[251:212]), .pci_i(),
	.pci_solo_o(pv[259:252]), .pci_solo_oe(pv[267:260]), .pci_solo_pin_o(),
	.pci_solo_pin_oe(ps_oe), .cell_if_enabled(cen), .pci_enabled(pen),
	.serial_port_two_enabled(sen));
spfs_board u_spfs_board (.aclk(aclk), .cell_pull(cell_pull), .pci_pull(pci_pull),
	.ext_gp(ext), .gp_pin_o(gp_o), .gp_pin_oe(gp_oe), .gp_pin_i(gp_i), .mux1_pin_o(m1_o),
	.mux1_pin_oe(m1_oe), .mux1_pin_i(m1_i), .mux2_pin_o(m2_o), .mux2_pin_oe(m2_oe),
	.mux2_pin_i(m2_i), .cell_if_select_strap(cstrap), .pci_select_strap(pstrap));
function automatic logic [31:0] xs();
	seed ^= seed << 13;
	seed ^= seed >> 17;
	seed ^= seed << 5;
	return seed;
endfunction
task automatic chk(input string n, input logic [95:0] x, input logic [95:0] s);
	tests_run++;
	if (s !== x) begin
		mismatches++;
		$display("[FAIL] %s exp %h got %h", n, x, s);
	end
endtask
task automatic final_report();
	$display("checks %0d mismatches %0d", tests_run, mismatches);
	if (mismatches == 0 && tests_run > 0)
		$display("[ PASS ]");
	else
		$display("[ FAIL ]");
	$finish;
endtask
// ---
// axi4-lite master; expected responses wait in the queues
// ---
task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
	bq.push_back(r);
	awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
	do begin
		@(posedge aclk);
		if (awready) awvalid <= 0;
		if (wready) wvalid <= 0;
	end while (!bvalid);
	bready <= 0;
	@(posedge aclk);
endtask
task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
	rq.push_back({r, d});
	araddr <= a; arvalid <= 1; rready <= 1;
	do begin
		@(posedge aclk);
		if (arready) arvalid <= 0;
	end while (!rvalid);
	rready <= 0;
	@(posedge aclk);
endtask
always @(posedge aclk) begin
	if (rvalid && rready) chk("read", rq.pop_front(), {rresp, rdata});
	if (bvalid && bready) chk("bresp", bq.pop_front(), bresp);
end
task automatic settle();
	repeat (3) @(posedge aclk);
endtask
// straps flip after capture so a late sample would show
task automatic rst(input logic c, input logic p);
	aresetn <= 0; cell_pull <= c; pci_pull <= p;
	repeat (6) @(posedge aclk);
	aresetn <= 1;
	repeat (2) @(posedge aclk);
	cell_pull <= ~c; pci_pull <= ~p;
	repeat (4) @(posedge aclk);
endtask
task automatic scramble();
	for (int i = 0; i < 9; i++) pv[i*32 +: 32] <= xs();
	ext <= 16'(xs());
	settle();
endtask
initial begin
	logic [15:0] dir, out;
	rst(0, 0);
	scramble();
	rd(`SPFS_STATUS_OFS, 32'h4, `SPFS_RESP_OKAY);
	rd(`SPFS_GPIO_EN_OFS, 32'h0, `SPFS_RESP_OKAY);
	chk("clk_pins", pv[31:0] & 32'h01060106, {gp_oe, gp_o} & 32'h01060106);
	chk("mux1", pv[45:32], {m1_oe, m1_o});
	chk("cell_solo", 0, cs_oe);
	chk("mux2", pv[171:92], {m2_oe, m2_o});
	chk("pci_solo", 0, ps_oe);
	dir = 16'(xs());
	out = 16'(xs());
	wr(`SPFS_GPIO_EN_OFS, 32'hFFFF, `SPFS_RESP_OKAY);
	wr(`SPFS_GPIO_DIR_OFS, {16'hFFFF, dir}, `SPFS_RESP_OKAY);
	wr(`SPFS_GPIO_OUT_OFS, {16'h0000, out}, `SPFS_RESP_OKAY);
	settle();
	chk("gp_oe", dir, gp_oe);
	chk("gp_o", dir & out, dir & gp_o);
	chk("periph_in_gpio", 0, pg_i);
	rd(`SPFS_GPIO_DIR_OFS, {16'h0000, dir}, `SPFS_RESP_OKAY);
	rd(`SPFS_GPIO_IN_OFS, {16'h0000, dir & out | ~dir & ext}, `SPFS_RESP_OKAY);
	wr(`SPFS_GPIO_EN_OFS, 32'h0, `SPFS_RESP_OKAY);
	settle();
	chk("gp_back", pv[31:0], {gp_oe, gp_o});
	chk("periph_in", pv[31:16] & pv[15:0] | ~pv[31:16] & ext, pg_i);
	wr(12'h020, 32'h1, `SPFS_RESP_SLVERR);
	rd(12'h020, 32'h0, `SPFS_RESP_SLVERR);
	wr(`SPFS_STATUS_OFS, 32'h0, `SPFS_RESP_OKAY);
	rd(`SPFS_STATUS_OFS, 32'h4, `SPFS_RESP_OKAY);
	// pci off: a low select must leave serial port two running
	sp2_sel <= 0;
	settle();
	rd(`SPFS_STATUS_OFS, 32'h4, `SPFS_RESP_OKAY);
	sp2_sel <= 1;
	rst(1, 1);
	scramble();
	rd(`SPFS_STATUS_OFS, 32'h7, `SPFS_RESP_OKAY);
	chk("mux1_cell", pv[59:46], {m1_oe, m1_o});
	chk("cell_solo_on", pv[75:68], cs_oe);
	chk("sp1_solo", 0, ss_oe);
	chk("mux2_pci", pv[251:172], {m2_oe, m2_o});
	chk("pci_solo_on", pv[267:260], ps_oe);
	sp2_sel <= 0;
	settle();
	rd(`SPFS_STATUS_OFS, 32'h3, `SPFS_RESP_OKAY);
	sp2_sel <= 1;
	wr(`SPFS_SP2_SEL_OFS, 32'h0, `SPFS_RESP_OKAY);
	settle();
	rd(`SPFS_STATUS_OFS, 32'h3, `SPFS_RESP_OKAY);
	wr(`SPFS_SP2_SEL_OFS, 32'h1, `SPFS_RESP_OKAY);
	wr(`SPFS_GPIO_EN_OFS, 32'hFFFF, `SPFS_RESP_OKAY);
	wr(`SPFS_GPIO_DIR_OFS, 32'hFFFF, `SPFS_RESP_OKAY);
	settle();
	chk("gp_pci", {pv[31:25], pv[15:9]}, {gp_oe[15:9], gp_o[15:9]});
	chk("gp_free", 9'h1FF, gp_oe[8:0]);
	// mixed straps: serial one keeps its pins while pci owns the host pins
	rst(0, 1);
	scramble();
	rd(`SPFS_STATUS_OFS, 32'h6, `SPFS_RESP_OKAY);
	chk("mux1_mixed", pv[45:32], {m1_oe, m1_o});
	chk("mux2_mixed", pv[251:172], {m2_oe, m2_o});
	chk("cell_solo_mixed", 0, cs_oe);
	final_report();
end
initial begin
	#100000;
	mismatches++;
	final_report();
end
endmodule
